// *** design/adcsc_top.sv ***
// Purpose: Converter sequencing control with AXI4-Lite registers
// Assumes: sys_clk at 50 MHz, synchronous active-low rst_n
// Notes:   Analog switches are driven as plain enables
//
// Functional notes
// - Reference from supply, pin or amplifier
// - Select 00 supply, 01 pin, 1x amplifier
// - Amplifier powered by its enable bit
// - Amplifier gain from two-bit select
// - Amplifier fed from pin or bandgap
// - Input select 0 pin, 1 bandgap
// - Internal reference disconnects external reference pins
// - Analog pin loses its original function
// - Analog pin loses its pull-high
// - Analog pin ignores port direction
// - External codes convert selected channel 0-15
// - Other codes route supply, amplifier or ground
// - Internal signal disconnects all external channels
// - Start bit low-high-low begins conversion
// - Busy set at start, cleared at end
// - Completion sets flag; interrupt only if enabled
// - Converter clock is system clock over 2^n
// - Converter powered only while enable high
// - Conversion takes 4 sample plus 12 periods
`timescale 1ns/1ps
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CHAN_N = 16,
  parameter int DATA_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DATA_W-1:0] sar_data,
  output logic                   converter_power_enable,
  output logic                   conv_clock_tick,
  output logic                   conv_sampling,
  output logic                   conv_busy_flag,
  output logic                   conv_irq,
  output logic                   ref_sel_supply,
  output logic                   ref_sel_ext_pin,
  output logic                   ref_sel_amp,
  output logic                   ext_ref_pin_connect,
  output logic                   ref_amp_enable,
  output logic [1:0]             ref_amp_gain_sel,
  output logic                   ref_amp_input_sel,
  output logic                   ext_amp_input_pin_connect,
  output logic [CHAN_N-1:0]      ext_channel_connect,
  output adcsc_isrc_e            internal_source,
  input  wire logic [CHAN_N-1:0] gpio_out,
  input  wire logic [CHAN_N-1:0] gpio_oe_n,
  input  wire logic [CHAN_N-1:0] gpio_pullup,
  output logic [CHAN_N-1:0]      gpio_in,
  input  wire logic [CHAN_N-1:0] pad_in,
  output logic [CHAN_N-1:0]      pad_out,
  output logic [CHAN_N-1:0]      pad_oe_n,
  output logic [CHAN_N-1:0]      pad_pullup
);

  logic [31:0]       ctrl_q;
  logic [31:0]       ref_q;
  logic [31:0]       pinsel_q;
  logic              irq_flag_q;
  logic [DATA_W-1:0] result_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_hit;
  logic              tick;
  logic              restart;
  logic              done;
  logic [3:0]        src_sel;
  logic [3:0]        chan_sel;
  logic              ext_selected;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // ==========================================================
  // AXI4-Lite write channel
  // Address and data are taken together; the master offers both at once
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_hit = (s_axi_awaddr == ADDR_W'(ADCSC_OFS_CTRL))
               || (s_axi_awaddr == ADDR_W'(ADCSC_OFS_REF))
               || (s_axi_awaddr == ADDR_W'(ADCSC_OFS_STATUS))
               || (s_axi_awaddr == ADDR_W'(ADCSC_OFS_RESULT))
               || (s_axi_awaddr == ADDR_W'(ADCSC_OFS_PINSEL));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ADCSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        res[8*b +: 8] = s_axi_wdata[8*b +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q   <= ADCSC_CTRL_RST;
      ref_q    <= ADCSC_REF_RST;
      pinsel_q <= ADCSC_PINSEL_RST;
    end else if (wr_fire) begin
      if (s_axi_awaddr == ADDR_W'(ADCSC_OFS_CTRL)) begin
        ctrl_q <= merge(ctrl_q, ADCSC_CTRL_MASK);
      end
      if (s_axi_awaddr == ADDR_W'(ADCSC_OFS_REF)) begin
        ref_q <= merge(ref_q, ADCSC_REF_MASK);
      end
      if (s_axi_awaddr == ADDR_W'(ADCSC_OFS_PINSEL)) begin
        pinsel_q <= merge(pinsel_q, ADCSC_PINSEL_MASK);
      end
    end
  end

  // Completion flag, write one to clear; a new completion wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_flag_q <= 1'b0;
    end else if (done) begin
      irq_flag_q <= 1'b1;
    end else if (wr_fire && s_axi_awaddr == ADDR_W'(ADCSC_OFS_STATUS)
                 && s_axi_wstrb[0] && s_axi_wdata[ADCSC_STAT_IRQ_BIT]) begin
      irq_flag_q <= 1'b0;
    end
  end

  assign conv_irq = irq_flag_q && ctrl_q[ADCSC_CTRL_IRQEN_BIT];

  // Result loads only at completion so a read never sees a half result
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (done) begin
      result_q <= sar_data;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign rd_fire       = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(ADCSC_OFS_CTRL):   rd_word = ctrl_q;
      ADDR_W'(ADCSC_OFS_REF):    rd_word = ref_q;
      ADDR_W'(ADCSC_OFS_PINSEL): rd_word = pinsel_q;
      ADDR_W'(ADCSC_OFS_RESULT): rd_word = 32'(result_q);
      ADDR_W'(ADCSC_OFS_STATUS): begin
        rd_word[ADCSC_STAT_BUSY_BIT] = conv_busy_flag;
        rd_word[ADCSC_STAT_IRQ_BIT]  = irq_flag_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= ADCSC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Reference path
  assign ref_sel_supply   = (ref_q[ADCSC_REF_SRC_LSB +: 2] == 2'h0);
  assign ref_sel_ext_pin  = (ref_q[ADCSC_REF_SRC_LSB +: 2] == 2'h1);
  assign ref_sel_amp      = ref_q[ADCSC_REF_SRC_LSB + 1];
  assign ext_ref_pin_connect = ref_sel_ext_pin;
  assign ref_amp_enable   = ref_q[ADCSC_REF_AMPEN_BIT];
  assign ref_amp_gain_sel = ref_q[ADCSC_REF_GAIN_LSB +: 2];
  assign ref_amp_input_sel = ref_q[ADCSC_REF_AMPIN_BIT];
  // Bandgap settling is left to software; the pin switch opens at once
  assign ext_amp_input_pin_connect = !ref_q[ADCSC_REF_AMPIN_BIT];

  // ==========================================================
  // Input routing
  assign src_sel  = ctrl_q[ADCSC_CTRL_SRC_LSB +: 4];
  assign chan_sel = ctrl_q[ADCSC_CTRL_CHAN_LSB +: 4];
  assign ext_selected = (src_sel[3:2] == 2'h3) || (!src_sel[3] && src_sel[1:0] == 2'h0);
  assign ext_channel_connect = ext_selected ? CHAN_N'(1) << chan_sel : '0;

  always_comb begin
    internal_source = ADCSC_ISRC_NONE;
    unique case (src_sel)
      4'h1: internal_source = ADCSC_ISRC_SUPPLY;
      4'h2: internal_source = ADCSC_ISRC_SUPPLY_DIV2;
      4'h3: internal_source = ADCSC_ISRC_SUPPLY_DIV4;
      4'h5: internal_source = ADCSC_ISRC_AMP;
      4'h6: internal_source = ADCSC_ISRC_AMP_DIV2;
      4'h7: internal_source = ADCSC_ISRC_AMP_DIV4;
      4'h8, 4'h9, 4'hA, 4'hB: internal_source = ADCSC_ISRC_GROUND;
      default: internal_source = ADCSC_ISRC_NONE;
    endcase
  end

  // ==========================================================
  // Pin takeover
  assign pad_out    = gpio_out & ~pinsel_q[CHAN_N-1:0];
  assign pad_oe_n   = gpio_oe_n | pinsel_q[CHAN_N-1:0];
  assign pad_pullup = gpio_pullup & ~pinsel_q[CHAN_N-1:0];
  assign gpio_in    = pad_in & ~pinsel_q[CHAN_N-1:0];

  // ==========================================================
  // Converter power, clock and sequence
  assign converter_power_enable = ctrl_q[ADCSC_CTRL_PWR_BIT];
  assign conv_clock_tick = tick;

  adcsc_clk_div u_clk_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (restart),
    .div_sel (ctrl_q[ADCSC_CTRL_DIV_LSB +: 3]),
    .tick    (tick)
  );

  adcsc_seq u_seq (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .start_bit (ctrl_q[ADCSC_CTRL_START_BIT]),
    .power_en  (converter_power_enable),
    .tick      (tick),
    .restart   (restart),
    .busy      (conv_busy_flag),
    .sampling  (conv_sampling),
    .done      (done)
  );

  // ==========================================================
  // Checks
  a_ref_one_hot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $onehot({ref_sel_supply, ref_sel_ext_pin, ref_sel_amp}))
    else $error("reference select not one-hot");
  a_ref_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ref_sel_supply || ref_sel_amp) |-> !ext_ref_pin_connect)
    else $error("external reference pin left connected");
  a_amp_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ref_amp_input_sel |-> !ext_amp_input_pin_connect)
    else $error("amplifier input pin left connected");
  a_ext_iso: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (internal_source != ADCSC_ISRC_NONE) |-> (ext_channel_connect == '0))
    else $error("external channel connected with internal source");
  a_ext_chan_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (internal_source == ADCSC_ISRC_NONE) |-> ext_channel_connect[chan_sel])
    else $error("selected channel not connected");
  a_pin_direction: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pad_oe_n & pinsel_q[CHAN_N-1:0]) == pinsel_q[CHAN_N-1:0])
    else $error("analog pin driven");
  a_pin_pullup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pad_pullup & pinsel_q[CHAN_N-1:0]) == '0)
    else $error("pull-high on analog pin");
  a_done_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done |=> irq_flag_q && (conv_irq == ctrl_q[ADCSC_CTRL_IRQEN_BIT]))
    else $error("completion flag not set");
  a_result_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(result_q) |-> $past(done) && !conv_busy_flag)
    else $error("result changed outside completion");
  a_power_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !converter_power_enable |=> !conv_busy_flag)
    else $error("conversion running without power");

endmodule : adcsc_top

// *** design/adcsc_pkg.sv ***
// Purpose: Shared constants and types for the converter sequencing control
// Assumes: 32-bit AXI4-Lite register bus, one system clock
// Notes:   Offsets are byte addresses of aligned words
package adcsc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADCSC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ADCSC_OFS_REF    = 8'h04;
  localparam logic [7:0] ADCSC_OFS_STATUS = 8'h08;
  localparam logic [7:0] ADCSC_OFS_RESULT = 8'h0C;
  localparam logic [7:0] ADCSC_OFS_PINSEL = 8'h10;

  // ==========================================================
  // Field positions
  localparam int ADCSC_CTRL_PWR_BIT   = 0;
  localparam int ADCSC_CTRL_START_BIT = 1;
  localparam int ADCSC_CTRL_IRQEN_BIT = 2;
  localparam int ADCSC_CTRL_CHAN_LSB  = 4;
  localparam int ADCSC_CTRL_SRC_LSB   = 8;
  localparam int ADCSC_CTRL_DIV_LSB   = 12;
  localparam int ADCSC_REF_GAIN_LSB   = 0;
  localparam int ADCSC_REF_SRC_LSB    = 2;
  localparam int ADCSC_REF_AMPIN_BIT  = 4;
  localparam int ADCSC_REF_AMPEN_BIT  = 7;
  localparam int ADCSC_STAT_BUSY_BIT  = 0;
  localparam int ADCSC_STAT_IRQ_BIT   = 1;

  // ==========================================================
  // Reset values and writable masks
  localparam logic [31:0] ADCSC_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] ADCSC_REF_RST     = 32'h0000_0000;
  localparam logic [31:0] ADCSC_PINSEL_RST  = 32'h0000_0000;
  localparam logic [31:0] ADCSC_CTRL_MASK   = 32'h0000_7FF7;
  localparam logic [31:0] ADCSC_REF_MASK    = 32'h0000_009F;
  localparam logic [31:0] ADCSC_PINSEL_MASK = 32'h0000_FFFF;

  // ==========================================================
  // Conversion timing in converter clock periods
  localparam logic [3:0] ADCSC_SAMPLE_TICKS  = 4'h4;
  localparam logic [3:0] ADCSC_CONVERT_TICKS = 4'hC;
  localparam logic [4:0] ADCSC_TOTAL_TICKS   = 5'h10;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] ADCSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ADCSC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ADCSC_ISRC_NONE, ADCSC_ISRC_SUPPLY, ADCSC_ISRC_SUPPLY_DIV2, ADCSC_ISRC_SUPPLY_DIV4,
    ADCSC_ISRC_AMP, ADCSC_ISRC_AMP_DIV2, ADCSC_ISRC_AMP_DIV4, ADCSC_ISRC_GROUND
  } adcsc_isrc_e;

  typedef enum logic [1:0] {ADCSC_ST_IDLE, ADCSC_ST_SAMPLE, ADCSC_ST_CONVERT} adcsc_state_e;

endpackage : adcsc_pkg

// *** design/adcsc_clk_div.sv ***
// Purpose: Converter clock prescaler, one tick per converter clock period
// Assumes: Synchronous active-low reset
// Notes:   Restart aligns the first period to the start of a conversion
`timescale 1ns/1ps
module adcsc_clk_div
  import adcsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  output logic            tick
);

  logic [6:0] cnt_q;
  logic [6:0] mask;

  // ==========================================================
  // Power-of-two divide
  assign mask = 7'(8'(8'h01 << div_sel) - 8'h01);
  assign tick = ((cnt_q & mask) == mask);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
    end else if (restart || tick) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= 7'(cnt_q + 7'h01);
    end
  end

  // ==========================================================
  // Checks
  a_div_one_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (div_sel == 3'h0) |-> tick)
    else $error("divide by one must tick every cycle");
  a_div_two_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (div_sel == 3'h1 && tick && !restart) ##1 (div_sel == 3'h1 && !restart) |-> !tick)
    else $error("divide by two ticked twice in a row");

endmodule : adcsc_clk_div

// *** design/adcsc_seq.sv ***
// Purpose: Conversion sequencer, start detection, busy and completion
// Assumes: tick marks one converter clock period
// Notes:   Dropping power aborts a conversion without completion
`timescale 1ns/1ps
module adcsc_seq
  import adcsc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic start_bit,
  input  wire logic power_en,
  input  wire logic tick,
  output logic      restart,
  output logic      busy,
  output logic      sampling,
  output logic      done
);

  adcsc_state_e state_q;
  logic [3:0]   cnt_q;
  logic         start_prev_q;
  logic [4:0]   ticks_seen_q;

  // ==========================================================
  // Start on low-high-low of the start bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
    end
  end

  assign restart  = start_prev_q && !start_bit && power_en && (state_q == ADCSC_ST_IDLE);
  assign busy     = (state_q != ADCSC_ST_IDLE);
  assign sampling = (state_q == ADCSC_ST_SAMPLE);
  assign done     = (state_q == ADCSC_ST_CONVERT) && tick && power_en
                    && (cnt_q == 4'(ADCSC_CONVERT_TICKS - 4'h1));

  // ==========================================================
  // Sample then convert
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ADCSC_ST_IDLE;
      cnt_q   <= 4'h0;
    end else if (!power_en) begin
      state_q <= ADCSC_ST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        ADCSC_ST_IDLE: begin
          if (restart) begin
            state_q <= ADCSC_ST_SAMPLE;
            cnt_q   <= 4'h0;
          end
        end
        ADCSC_ST_SAMPLE: begin
          if (tick && cnt_q == 4'(ADCSC_SAMPLE_TICKS - 4'h1)) begin
            state_q <= ADCSC_ST_CONVERT;
            cnt_q   <= 4'h0;
          end else if (tick) begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
        ADCSC_ST_CONVERT: begin
          if (done) begin
            state_q <= ADCSC_ST_IDLE;
            cnt_q   <= 4'h0;
          end else if (tick) begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !busy) begin
      ticks_seen_q <= 5'h00;
    end else if (tick) begin
      ticks_seen_q <= 5'(ticks_seen_q + 5'h01);
    end
  end

  a_start_sets_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart |=> busy && sampling)
    else $error("start sequence did not begin a conversion");
  a_conv_tick_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done |-> (5'(ticks_seen_q + 5'h01) == ADCSC_TOTAL_TICKS))
    else $error("conversion did not last sixteen periods");
  a_done_clears_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done |=> !busy)
    else $error("busy still set after completion");

endmodule : adcsc_seq

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the converter sequencing control
// Assumes: 50 MHz sys_clk, AXI4-Lite master in tasks
// Notes:   Random stimulus from a fixed seed, corner cases among it
`timescale 1ns/1ps
module tb_top
  import adcsc_pkg::*;
;
  // ==========================================================
  // Signals
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ref_amp_gain_sel;
  logic [11:0] sar_data = '0;
  logic        converter_power_enable, conv_clock_tick, conv_sampling, conv_busy_flag;
  logic        conv_irq, ref_sel_supply, ref_sel_ext_pin, ref_sel_amp, ext_ref_pin_connect;
  logic        ref_amp_enable, ref_amp_input_sel, ext_amp_input_pin_connect;
  logic [15:0] ext_channel_connect, gpio_in, pad_out, pad_oe_n, pad_pullup;
  logic [15:0] gpio_out = '0, gpio_oe_n = '0, gpio_pullup = '0, pad_in = '0;
  adcsc_isrc_e internal_source;
  int          errors = 0, total_checks = 0, cycles = 0, seed = 80924;

  always #10 sys_clk = ~sys_clk;

  adcsc_top dut (.*);

  // ==========================================================
  // Checking and bus tasks
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready is combinational: look at it mid-cycle, release after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do @(negedge sys_clk); while (s_axi_awready !== 1'h1);
    @(posedge sys_clk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid  <= 1'h0;
    do @(negedge sys_clk); while (s_axi_bvalid !== 1'h1);
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(negedge sys_clk); while (s_axi_arready !== 1'h1);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge sys_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask : rchk

  // Start needs low, high, low; the fall launches the conversion
  // First write powers up and lets settling pass before start rises
  task automatic pulse(input logic [31:0] v);
    wr(ADCSC_OFS_CTRL, v);
    wr(ADCSC_OFS_CTRL, v | 32'h0000_0002);
    wr(ADCSC_OFS_CTRL, v);
  endtask : pulse

  function automatic logic [2:0] exp_src(input logic [3:0] s);
    if (s[3:2] == 2'h2)
      return 3'h7;
    if (s[3] || s[1:0] == 2'h0)
      return 3'h0;
    return s[2] ? 3'(s[1:0]) + 3'h3 : 3'(s[1:0]);
  endfunction : exp_src

  // ==========================================================
  // Timeout
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v, d;
    logic [1:0]  r;
    int          n, m, t;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0000_0000);
    rd(8'h14, d, r);
    chk(r, ADCSC_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      v = ($random(seed) & ADCSC_REF_MASK & 32'hFFFF_FFE3) | (i << 2);
      // Bandgap taken as already settled when bit4 selects it
      wr(ADCSC_OFS_REF, v);
      rchk(ADCSC_OFS_REF, v);
      chk({ref_sel_supply, ref_sel_ext_pin, ref_sel_amp}, v[3] ? 1 : (v[2] ? 2 : 4));
      chk(ext_ref_pin_connect, v[3:2] == 2'h1);
      chk({ref_amp_enable, ref_amp_gain_sel}, {v[7], v[1:0]});
      chk({ref_amp_input_sel, ext_amp_input_pin_connect}, {v[4], ~v[4]});
    end
    for (int i = 0; i < 16; i++) begin
      v = ($random(seed) & 32'h0000_00F0) | (i << 8);
      wr(ADCSC_OFS_CTRL, v);
      chk(internal_source, exp_src(v[11:8]));
      chk(ext_channel_connect, exp_src(v[11:8]) == 3'h0 ? 16'h1 << v[7:4] : 16'h0);
    end
    repeat (4) begin
      gpio_out    <= 16'($random(seed));
      gpio_oe_n   <= 16'($random(seed));
      gpio_pullup <= 16'($random(seed));
      pad_in      <= 16'($random(seed));
      v = $random(seed) & ADCSC_PINSEL_MASK;
      wr(ADCSC_OFS_PINSEL, v);
      @(negedge sys_clk);
      chk({gpio_in, pad_out}, {pad_in & ~v[15:0], gpio_out & ~v[15:0]});
      chk(pad_pullup, gpio_pullup & ~v[15:0]);
      chk(pad_oe_n, gpio_oe_n | v[15:0]);
    end
    // Every divider code; odd codes enable the interrupt
    // Period range is software's concern; all codes still divide
    for (int k = 0; k < 8; k++) begin
      v = 32'h0000_0001 | (k[0] << 2) | (k << 12);
      sar_data <= 12'($random(seed));
      pulse(v);
      chk(converter_power_enable, 1'h1);
      n = 0;
      m = 0;
      t = 0;
      do @(negedge sys_clk); while (conv_busy_flag !== 1'h1);
      while (conv_busy_flag === 1'h1) begin
        n++;
        m += int'(conv_sampling);
        t += int'(conv_clock_tick);
        @(negedge sys_clk);
      end
      chk(t, 16);
      chk(n, 16 << k);
      chk(m, 4 << k);
      chk(conv_irq, k[0]);
      rchk(ADCSC_OFS_RESULT, 32'(sar_data));
      rchk(ADCSC_OFS_STATUS, 32'h0000_0002);
      wr(ADCSC_OFS_STATUS, 32'h0000_0002);
      rchk(ADCSC_OFS_STATUS, 32'h0000_0000);
    end
    // Power dropped mid-conversion, then a start while unpowered
    pulse(32'h0000_7001);
    do @(negedge sys_clk); while (conv_busy_flag !== 1'h1);
    wr(ADCSC_OFS_CTRL, 32'h0000_7002);
    wr(ADCSC_OFS_CTRL, 32'h0000_7000);
    repeat (4) @(negedge sys_clk);
    chk({converter_power_enable, conv_busy_flag}, 2'h0);
    rchk(ADCSC_OFS_STATUS, 32'h0000_0000);
    summarize();
  end
endmodule : tb_top
